// >>> common/sfpi_pkg.sv
package sfpi_pkg;

	typedef enum logic [1:0] {
		SFPI_LANE_SINGLE,
		SFPI_LANE_DUAL,
		SFPI_LANE_QUAD
	} sfpi_lanes_t;

	localparam int SFPI_BYTE_W = 8;
	localparam int SFPI_LANES = 4;
	localparam int SFPI_SYNC_W = 7;
	localparam int SFPI_SR_W = 8;
	localparam int SFPI_SR_LOCK_POS = 7;
	localparam int SFPI_SR_QE_POS = 6;
	localparam int SFPI_SR_BP_LSB = 2;
	localparam int SFPI_SR_BP_W = 4;
	localparam logic [7:0] SFPI_SR_RESET = 8'h00;
	localparam logic [6:0] SFPI_SYNC_INIT = 7'h7F;
	localparam logic [3:0] SFPI_OE_NONE = 4'hF;
	localparam logic [3:0] SFPI_OE_SINGLE = 4'hD;
	localparam logic [3:0] SFPI_OE_DUAL = 4'hC;
	localparam logic [3:0] SFPI_OE_QUAD = 4'h0;
	localparam int SFPI_PAGE_SMALL = 256;
	localparam int SFPI_PAGE_LARGE = 512;
	localparam int SFPI_PAGE_CNT_W = 10;
	localparam int SFPI_BYTE_CNT_W = 16;

endpackage

// >>> hdl/sfpi_front.sv
`timescale 1ns/1ps
// Operation
// - Chip select high deselects, floats outputs, enters standby.
// - Serial input ignored while chip select is high.
// - First instruction needs a chip select falling edge after reset.
// - Single lane input sampled on rising serial clock edges.
// - Single lane output driven from falling serial clock edges.
// - Dual and quad lanes sample on rise, drive from fall.
// - Quad uses protect pin as lane 2, pause pin as lane 3.
// - Lock bit set and protect pin low block protected status writes.
// - Lock bit clear leaves status writable regardless of protect pin.
// - Quad enable turns protect pin into a data lane only.
// - Quad enable removes pause and reset from the shared pin.
// - No dedicated reset: select bit picks pause or reset.
// - Enabled dedicated reset: shared pin only pauses.
// - Disabled dedicated reset: select bit picks pause or reset.
// - Function register bit 0 set disables dedicated reset.
// - Pause suspends transfer, keeps partial sequence, resumes after.
// - Pause while selected floats the serial output.
// - Reset pin low holds reset and floats outputs.
// - Quad command mode moves instruction in two clocks.
// - Page program accepts one byte up to a full page.
// - Double edge transfers use both serial clock edges.
module sfpi_front
	import sfpi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic sck,
	input wire logic [3:0] io_lane_in,
	output logic [3:0] io_lane_out,
	output logic [3:0] io_lane_oe_n,
	input wire logic dedicated_reset_n,
	input wire logic has_dedicated_reset,
	input wire logic dedicated_reset_off,
	input wire logic pin_function_select_bit,
	input wire logic quad_command_mode,
	input wire logic double_edge_transfer,
	input wire sfpi_lanes_t data_lanes,
	input wire logic tx_enable,
	input wire logic [7:0] tx_byte,
	input wire logic status_wr_req,
	input wire logic [7:0] status_wr_data,
	input wire logic prog_data_phase,
	input wire logic page_512,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic rx_instr,
	output logic tx_ack,
	output logic [15:0] byte_count,
	output logic [7:0] status_reg,
	output logic status_wr_blocked,
	output logic selected,
	output logic standby,
	output logic paused,
	output logic in_reset,
	output logic [9:0] prog_count,
	output logic prog_full,
	output logic prog_wrap
);
	function automatic logic [3:0] lane_count(input sfpi_lanes_t m);
		case (m)
			SFPI_LANE_DUAL: lane_count = 4'h2;
			SFPI_LANE_QUAD: lane_count = 4'h4;
			default: lane_count = 4'h1;
		endcase
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] b,
		input logic [3:0] l, input sfpi_lanes_t m);
		case (m)
			SFPI_LANE_DUAL: shift_in = {b[5:0], l[1:0]};
			SFPI_LANE_QUAD: shift_in = {b[3:0], l};
			default: shift_in = {b[6:0], l[0]};
		endcase
	endfunction

	function automatic logic [3:0] lane_drive(input logic [7:0] b,
		input sfpi_lanes_t m);
		case (m)
			SFPI_LANE_DUAL: lane_drive = {2'h0, b[7:6]};
			SFPI_LANE_QUAD: lane_drive = b[7:4];
			default: lane_drive = {2'h0, b[7], 1'b0};
		endcase
	endfunction

	function automatic logic [3:0] lane_oe(input sfpi_lanes_t m);
		case (m)
			SFPI_LANE_DUAL: lane_oe = SFPI_OE_DUAL;
			SFPI_LANE_QUAD: lane_oe = SFPI_OE_QUAD;
			default: lane_oe = SFPI_OE_SINGLE;
		endcase
	endfunction

	logic [6:0] pins_s;
	logic cs_s, sck_s, rst_pin_s;
	logic [3:0] io_s;
	logic cs_prev_q, sck_prev_q;
	logic cs_fall, cs_rise, sck_rise, sck_fall;
	logic protect_func, pause_func, shared_reset_func, dedicated_reset_func;
	logic dev_reset, sel_now, pause_now, dtr;
	logic sample_edge, drive_edge, do_sample, do_drive;
	logic armed_q, instr_phase_q, dtr_live_q;
	logic [7:0] shift_q, shift_next, tx_shift_q, tx_src;
	logic [3:0] bit_cnt_q, tx_cnt_q, rx_step, tx_step;
	sfpi_lanes_t rx_mode, tx_mode;
	logic [9:0] page_size;
	logic sr_block;

	// Select syncs in low: a pin held low through reset is no fall
	sfpi_sync #(.W(SFPI_SYNC_W), .INIT(SFPI_SYNC_INIT & 7'h3F)) u_sync (
		.clk(sys_clk),
		.reset_n(reset_n),
		.d({chip_select_n, sck, dedicated_reset_n, io_lane_in}),
		.q(pins_s)
	);
	assign cs_s = pins_s[6];
	assign sck_s = pins_s[5];
	assign rst_pin_s = pins_s[4];
	assign io_s = pins_s[3:0];

	sfpi_pin_func u_func (
		.quad_enable_bit(status_reg[SFPI_SR_QE_POS]),
		.has_dedicated_reset(has_dedicated_reset),
		.dedicated_reset_off(dedicated_reset_off),
		.pin_function_select_bit(pin_function_select_bit),
		.protect_func(protect_func),
		.pause_func(pause_func),
		.shared_reset_func(shared_reset_func),
		.dedicated_reset_func(dedicated_reset_func)
	);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_prev_q <= 1'b0;
			sck_prev_q <= 1'b1;
		end else begin
			cs_prev_q <= cs_s;
			sck_prev_q <= sck_s;
		end
	end

	assign cs_fall = cs_prev_q && !cs_s;
	assign cs_rise = !cs_prev_q && cs_s;
	assign sck_rise = !sck_prev_q && sck_s;
	assign sck_fall = sck_prev_q && !sck_s;

	assign dev_reset = (dedicated_reset_func && !rst_pin_s) ||
		(shared_reset_func && !io_s[3]);
	assign sel_now = !cs_s && armed_q && !dev_reset;
	assign pause_now = sel_now && pause_func && !io_s[3];
	assign dtr = double_edge_transfer && dtr_live_q;
	// Both modes 0 and 3 give the same edge roles
	assign sample_edge = sck_rise || (dtr && sck_fall);
	assign drive_edge = sck_fall || (dtr && sck_rise);
	assign do_sample = sel_now && !pause_now && !tx_enable && sample_edge;
	assign do_drive = sel_now && !pause_now && tx_enable && drive_edge;

	// Instruction runs single lane unless quad command mode
	assign rx_mode = instr_phase_q ?
		(quad_command_mode ? SFPI_LANE_QUAD : SFPI_LANE_SINGLE) :
		data_lanes;
	assign tx_mode = data_lanes;
	assign rx_step = lane_count(rx_mode);
	assign tx_step = lane_count(tx_mode);
	assign shift_next = shift_in(shift_q, io_s, rx_mode);
	assign tx_src = (tx_cnt_q == 4'h0) ? tx_byte : tx_shift_q;

	// Armed only by a select edge, so a low level at power-up is not enough
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			armed_q <= 1'b0;
		end else if (dev_reset) begin
			armed_q <= 1'b0;
		end else if (cs_fall) begin
			armed_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_q <= 8'h00;
			bit_cnt_q <= 4'h0;
			instr_phase_q <= 1'b1;
			byte_count <= 16'h0000;
			rx_byte <= 8'h00;
			rx_valid <= 1'b0;
			rx_instr <= 1'b0;
			dtr_live_q <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			rx_instr <= 1'b0;
			// The fall after the last instruction bit carries no data
			dtr_live_q <= dtr_live_q ||
				(sel_now && sck_rise && !instr_phase_q);
			if (cs_rise || dev_reset || cs_s) begin
				bit_cnt_q <= 4'h0;
				dtr_live_q <= 1'b0;
				byte_count <= 16'h0000;
				instr_phase_q <= 1'b1;
			end else if (do_sample) begin
				shift_q <= shift_next;
				if (bit_cnt_q + rx_step == 4'h8) begin
					bit_cnt_q <= 4'h0;
					rx_byte <= shift_next;
					rx_valid <= 1'b1;
					rx_instr <= instr_phase_q;
					instr_phase_q <= 1'b0;
					byte_count <= byte_count + 16'h0001;
				end else begin
					bit_cnt_q <= bit_cnt_q + rx_step;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_shift_q <= 8'h00;
			tx_cnt_q <= 4'h0;
			tx_ack <= 1'b0;
			io_lane_out <= 4'h0;
		end else begin
			tx_ack <= 1'b0;
			if (cs_rise || dev_reset || cs_s) begin
				tx_cnt_q <= 4'h0;
			end else if (do_drive) begin
				io_lane_out <= lane_drive(tx_src, tx_mode);
				tx_shift_q <= tx_src << tx_step;
				tx_ack <= (tx_cnt_q == 4'h0);
				tx_cnt_q <= (tx_cnt_q + tx_step == 4'h8) ? 4'h0 :
					tx_cnt_q + tx_step;
			end
		end
	end

	// Lanes float when deselected, paused or reset
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			io_lane_oe_n <= SFPI_OE_NONE;
		end else if (!sel_now || pause_now || !tx_enable) begin
			io_lane_oe_n <= SFPI_OE_NONE;
		end else if (do_drive) begin
			io_lane_oe_n <= lane_oe(tx_mode);
		end
	end

	assign sr_block = status_reg[SFPI_SR_LOCK_POS] && protect_func &&
		!io_s[2];

	// All eight status bits are held here, written together from status_wr_data
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_reg <= SFPI_SR_RESET;
			status_wr_blocked <= 1'b0;
		end else begin
			status_wr_blocked <= 1'b0;
			if (status_wr_req && !dev_reset) begin
				if (sr_block) begin
					status_wr_blocked <= 1'b1;
				end else begin
					status_reg <= status_wr_data;
				end
			end
		end
	end

	assign page_size = page_512 ? 10'(SFPI_PAGE_LARGE) :
		10'(SFPI_PAGE_SMALL);

	// Extra bytes wrap to the page start rather than spill over
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prog_count <= 10'h000;
			prog_full <= 1'b0;
			prog_wrap <= 1'b0;
		end else begin
			prog_wrap <= 1'b0;
			if (cs_rise || dev_reset) begin
				prog_count <= 10'h000;
				prog_full <= 1'b0;
			end else if (do_sample && prog_data_phase &&
				bit_cnt_q + rx_step == 4'h8) begin
				if (prog_full) begin
					prog_wrap <= 1'b1;
					prog_count <= 10'h001;
					prog_full <= (page_size == 10'h001);
				end else begin
					prog_count <= prog_count + 10'h001;
					prog_full <= (prog_count + 10'h001 == page_size);
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			selected <= 1'b0;
			standby <= 1'b1;
			paused <= 1'b0;
			in_reset <= 1'b0;
		end else begin
			selected <= sel_now;
			standby <= cs_s || dev_reset;
			paused <= pause_now;
			in_reset <= dev_reset;
		end
	end

	a_deselect_hiz: assert property (@(posedge sys_clk)
		disable iff (!reset_n) cs_s |=> io_lane_oe_n == SFPI_OE_NONE)
		else $error("lanes driven while deselected");

	a_ignore_deselect: assert property (@(posedge sys_clk)
		disable iff (!reset_n) cs_s |=> !rx_valid)
		else $error("byte taken while deselected");

	a_need_cs_fall: assert property (@(posedge sys_clk)
		disable iff (!reset_n) !armed_q && !cs_fall |=> !armed_q)
		else $error("armed without select edge");

	a_rise_sample: assert property (@(posedge sys_clk)
		disable iff (!reset_n) rx_valid && !$past(dtr) |-> $past(sck_rise))
		else $error("byte completed off a rising edge");

	a_fall_drive: assert property (@(posedge sys_clk)
		disable iff (!reset_n) tx_ack && !$past(dtr) |-> $past(sck_fall))
		else $error("output loaded off a falling edge");

	a_quad_instr: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		rx_instr && $past(quad_command_mode) |-> $past(rx_step) == 4'h4)
		else $error("quad instruction not four lanes");

	a_status_locked: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		status_wr_req && !dev_reset && status_reg[SFPI_SR_LOCK_POS] &&
		!status_reg[SFPI_SR_QE_POS] && !io_s[2]
		|=> status_wr_blocked && $stable(status_reg))
		else $error("locked status changed");

	a_status_open: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		status_wr_req && !dev_reset && !status_reg[SFPI_SR_LOCK_POS]
		|=> status_reg == $past(status_wr_data))
		else $error("unlocked status write lost");

	a_pause_hiz: assert property (@(posedge sys_clk)
		disable iff (!reset_n) pause_now |=> io_lane_oe_n[1] && paused)
		else $error("output driven during pause");

	a_reset_hiz: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		dev_reset |=> in_reset && io_lane_oe_n == SFPI_OE_NONE)
		else $error("output driven in reset");

	a_cs_clear: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		cs_rise |=> bit_cnt_q == 4'h0 && byte_count == 16'h0000)
		else $error("counters kept after deselect");

endmodule // sfpi_front

// >>> hdl/sfpi_pin_func.sv
`timescale 1ns/1ps
module sfpi_pin_func (
	input wire logic quad_enable_bit,
	input wire logic has_dedicated_reset,
	input wire logic dedicated_reset_off,
	input wire logic pin_function_select_bit,
	output logic protect_func,
	output logic pause_func,
	output logic shared_reset_func,
	output logic dedicated_reset_func
);
	logic shared_follows_sel;

	// Quad lanes take both shared pins
	assign protect_func = !quad_enable_bit;
	assign shared_follows_sel = !has_dedicated_reset || dedicated_reset_off;
	assign shared_reset_func = !quad_enable_bit && shared_follows_sel &&
		pin_function_select_bit;
	assign pause_func = !quad_enable_bit && !shared_reset_func;
	assign dedicated_reset_func = has_dedicated_reset &&
		!dedicated_reset_off;
endmodule // sfpi_pin_func

// >>> hdl/sfpi_sync.sv
`timescale 1ns/1ps
module sfpi_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= INIT;
			q <= INIT;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // sfpi_sync

// >>> sim/sfpi_front_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		$display("unexpected at %0t: %h vs %h", $time, (g), (e)); \
		num_errors++; \
	end \
end
module sfpi_front_tb_top
	import sfpi_pkg::*;
;
	logic sys_clk = 1'b0;
	logic float_q = 1'b0;
	logic reset_n, h_cs_n, h_sck, ded_rst_n, has_ded, ded_off, pfs, qcm, de;
	logic tx_en, wr_req, pdp, p512, rx_valid, rx_instr, blocked;
	logic standby, paused, in_reset, prog_full;
	logic ack, sel, wrap;
	sfpi_lanes_t lanes_q;
	logic [3:0] pin_w, h_drv, h_oe_n, oe_n, lo, oe_x;
	logic [7:0] tx_q, wr_d, exp_sr, got, b, rx_byte, status_reg;
	logic [8:0] e9;
	logic [15:0] byte_count;
	logic [9:0] prog_count;
	logic [8:0] exp_q[$];
	int num_errors = 0;
	int checks_done = 0;
	int acks = 0;
	int wraps = 0;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) float_q <= ~float_q;
	// Released lanes toggle so a stale level never passes
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_w[i] = !oe_n[i] ? lo[i] : !h_oe_n[i] ? h_drv[i] : float_q;
		end
	end
	sfpi_host_model host (.chip_select_n(h_cs_n), .sck(h_sck), .drv(h_drv),
		.drv_oe_n(h_oe_n), .lanes(pin_w));
	sfpi_front DUT (.sys_clk(sys_clk), .reset_n(reset_n),
		.chip_select_n(h_cs_n), .sck(h_sck), .io_lane_in(pin_w),
		.io_lane_out(lo), .io_lane_oe_n(oe_n), .dedicated_reset_n(ded_rst_n),
		.has_dedicated_reset(has_ded), .dedicated_reset_off(ded_off),
		.pin_function_select_bit(pfs), .quad_command_mode(qcm),
		.double_edge_transfer(de), .data_lanes(lanes_q), .tx_enable(tx_en),
		.tx_byte(tx_q), .status_wr_req(wr_req), .status_wr_data(wr_d),
		.prog_data_phase(pdp), .page_512(p512), .rx_byte(rx_byte),
		.rx_valid(rx_valid), .rx_instr(rx_instr), .tx_ack(ack),
		.byte_count(byte_count), .status_reg(status_reg),
		.status_wr_blocked(blocked), .selected(sel), .standby(standby),
		.paused(paused), .in_reset(in_reset), .prog_count(prog_count),
		.prog_full(prog_full), .prog_wrap(wrap));
	always @(posedge sys_clk) begin
		if (ack === 1'b1) acks++;
		if (wrap === 1'b1) wraps++;
		if (rx_valid === 1'b1) begin
			`CHK(exp_q.size() > 0, 1'b1)
			e9 = exp_q.size() > 0 ? exp_q.pop_front() : 9'h000;
			`CHK({rx_instr, rx_byte}, e9)
		end
	end
	task results;
		$display("errors %0d, checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task wait_rx;
		for (int i = 0; i < 30 && exp_q.size() != 0; i++) @(posedge sys_clk);
		#1 `CHK(exp_q.size(), 0)
	endtask
	task wr_status(input logic [7:0] d, input logic prot);
		logic blk;
		host.set_pin(2, prot);
		repeat (4) @(posedge sys_clk);
		blk = exp_sr[7] && !exp_sr[6] && !prot;
		wr_d <= d;
		wr_req <= 1'b1;
		@(posedge sys_clk) wr_req <= 1'b0;
		#1 if (!blk) exp_sr = d;
		`CHK(status_reg, exp_sr)
		`CHK(blocked, blk)
	endtask
	// Instruction byte, then n data bytes, left selected
	task xfer(input int wi, input int w, input logic dt, input int n);
		logic [7:0] d;
		host.select();
		d = 8'($urandom);
		exp_q.push_back({1'b1, d});
		host.send(d, wi, 1'b0, 8 / wi);
		for (int k = 0; k < n; k++) begin
			d = 8'($urandom);
			exp_q.push_back({1'b0, d});
			host.send(d, w, dt, 8 / w);
		end
		wait_rx;
	endtask
	task desel;
		host.deselect();
		`CHK(oe_n, SFPI_OE_NONE)
		`CHK(standby, 1'b1)
		`CHK(sel, 1'b0)
	endtask
	initial begin
		#500000;
		num_errors++;
		results();
	end
	initial begin
		reset_n = 1'b0;
		{ded_rst_n, has_ded} = 2'b11;
		{ded_off, pfs, qcm, de, tx_en, wr_req, pdp, p512} = 8'h00;
		lanes_q = SFPI_LANE_SINGLE;
		{tx_q, wr_d, b} = 24'h000000;
		exp_sr = SFPI_SR_RESET;
		void'($urandom(33));
		host.select();
		repeat (10) @(posedge sys_clk);
		`CHK(oe_n, SFPI_OE_NONE)
		`CHK(status_reg, SFPI_SR_RESET)
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		host.send(8'hA5, 1, 1'b0, 8);
		host.deselect();
		host.send(8'h3C, 1, 1'b0, 8);
		`CHK(standby, 1'b1)
		for (int i = 0; i < 8; i++) begin
			wr_status({i[2], i[1], 6'h00}, 1'b1);
			wr_status(8'($urandom), i[0]);
		end
		wr_status(8'h00, 1'b1);
		b = 8'($urandom);
		host.select();
		exp_q.push_back({1'b1, b});
		host.send(b, 1, 1'b0, 4);
		host.set_pin(3, 1'b0);
		repeat (6) @(posedge sys_clk);
		#1 `CHK(paused, 1'b1)
		`CHK(sel, 1'b1)
		`CHK(oe_n[1], 1'b1)
		// Edges during the pause must not shift
		host.send(~b, 1, 1'b0, 3);
		host.set_pin(3, 1'b1);
		repeat (6) @(posedge sys_clk);
		host.send({b[3:0], 4'h0}, 1, 1'b0, 4);
		wait_rx;
		desel;
		for (int v = 0; v < 3; v++) begin
			@(posedge sys_clk) de <= v == 2;
			lanes_q <= v == 1 ? SFPI_LANE_DUAL : SFPI_LANE_SINGLE;
			xfer(1, v == 1 ? 2 : 1, v == 2, 2);
			`CHK(byte_count, 16'h0003)
			desel;
		end
		de <= 1'b0;
		wr_status(8'h40, 1'b1);
		for (int m = 0; m < 3; m++) begin
			oe_x = m == 0 ? SFPI_OE_SINGLE : m == 1 ? SFPI_OE_DUAL : SFPI_OE_QUAD;
			@(posedge sys_clk) lanes_q <= sfpi_lanes_t'(m);
			xfer(1, 1, 1'b0, 0);
			@(posedge sys_clk) tx_q <= 8'($urandom);
			tx_en <= 1'b1;
			host.recv(1 << m, 8 >> m, got);
			`CHK(got, tx_q)
			`CHK(oe_n, oe_x)
			`CHK(acks, m + 1)
			@(posedge sys_clk) tx_en <= 1'b0;
			desel;
		end
		@(posedge sys_clk) qcm <= 1'b1;
		lanes_q <= SFPI_LANE_QUAD;
		xfer(4, 4, 1'b0, 0);
		@(posedge sys_clk) pdp <= 1'b1;
		// One wrap of the small page, then fill a large page
		for (int k = 1; k <= 3 * SFPI_PAGE_SMALL; k++) begin
			if (k == SFPI_PAGE_SMALL + 2)
				@(posedge sys_clk) p512 <= 1'b1;
			b = 8'($urandom);
			exp_q.push_back({1'b0, b});
			host.send(b, 4, 1'b0, 2);
			wait_rx;
			if (k == SFPI_PAGE_SMALL || k == 3 * SFPI_PAGE_SMALL)
				`CHK(prog_full, 1'b1)
			if (k == SFPI_PAGE_SMALL)
				`CHK(prog_count, 10'h100)
			if (k == SFPI_PAGE_SMALL + 1)
				`CHK(prog_count, 10'h001)
			if (k == 2 * SFPI_PAGE_SMALL)
				`CHK(prog_full, 1'b0)
			if (k == 3 * SFPI_PAGE_SMALL)
				`CHK(prog_count, 10'h200)
		end
		`CHK(wraps, 1)
		@(posedge sys_clk) pdp <= 1'b0;
		qcm <= 1'b0;
		desel;
		for (int i = 0; i < 16; i++) begin
			wr_status({1'b0, i[3], 6'h00}, 1'b1);
			@(posedge sys_clk) has_ded <= i[2];
			ded_off <= i[1];
			pfs <= i[0];
			host.set_pin(3, 1'b0);
			repeat (6) @(posedge sys_clk);
			#1 `CHK(in_reset, !i[3] && i[0] && (!i[2] || i[1]))
			`CHK(oe_n, SFPI_OE_NONE)
			host.set_pin(3, 1'b1);
			// No internal write is running here
			@(posedge sys_clk) ded_rst_n <= 1'b0;
			repeat (6) @(posedge sys_clk);
			#1 `CHK(in_reset, i[2] && !i[1])
			@(posedge sys_clk) ded_rst_n <= 1'b1;
			repeat (6) @(posedge sys_clk);
		end
		results();
	end
endmodule // sfpi_front_tb_top

// >>> sim/sfpi_host_model.sv
`timescale 1ns/1ps
module sfpi_host_model (
	output logic chip_select_n,
	output logic sck,
	output logic [3:0] drv,
	output logic [3:0] drv_oe_n,
	input wire logic [3:0] lanes
);
	localparam real HALF = 62.5;
	localparam real QTR = 31.25;
	// Mode 0, clock parked low outside frames
	initial begin
		chip_select_n = 1'b1;
		sck = 1'b0;
		drv = 4'hD;
		drv_oe_n = 4'h2;
	end
	task automatic select();
		chip_select_n = 1'b0;
		#HALF;
	endtask
	task automatic deselect();
		#HALF;
		chip_select_n = 1'b1;
		#HALF;
	endtask
	// Pin 2 is the protect level, pin 3 pause or shared reset
	task automatic set_pin(input int idx, input logic v);
		drv[idx] = v;
	endtask
	// Data moves mid half period so it never races the edge
	task automatic send(input logic [7:0] d, input int w, input logic dt,
		input int n);
		logic [7:0] sh;
		sh = d;
		for (int g = 0; g < n; g++) begin
			#QTR;
			for (int i = 0; i < w; i++) begin
				drv[i] = sh[8 - w + i];
				drv_oe_n[i] = 1'b0;
			end
			sh = sh << w;
			#QTR;
			sck = ~sck;
			if (!dt) begin
				#HALF;
				sck = 1'b0;
			end
		end
		#HALF;
		if (w == 4)
			drv[3:2] = 2'b11;
		drv_oe_n = 4'h2;
	endtask
	// Sampled where the next rise would latch it
	task automatic recv(input int w, input int n, output logic [7:0] d);
		d = 8'h00;
		for (int i = 0; i < w; i++) begin
			drv_oe_n[i] = 1'b1;
		end
		for (int g = 0; g < n; g++) begin
			#HALF;
			sck = 1'b1;
			#HALF;
			sck = 1'b0;
			#HALF;
			d = d << w;
			for (int i = 0; i < w; i++) begin
				d[i] = w == 1 ? lanes[1] : lanes[i];
			end
		end
		drv_oe_n = 4'h2;
	endtask
endmodule // sfpi_host_model
